// ===== common/cps_pkg.sv
package cps_pkg;

    // ************************************************************
    // Widths and reset values
    // ************************************************************
    localparam int          PC_W        = 13;
    localparam int          INSTR_W     = 16;
    localparam int          STACK_DEPTH = 12;
    localparam int          BANK_LSB    = 5;
    localparam logic [12:0] RESET_PC    = 13'h0000;
    localparam logic [7:0]  BANK_RESET  = 8'h00;
    localparam logic [1:0]  BANK_MASK   = 2'h3;

    // ************************************************************
    // Instruction phases, one cycle each
    // ************************************************************
    localparam logic [1:0] PH_T1 = 2'h0;
    localparam logic [1:0] PH_T4 = 2'h3;

    // ************************************************************
    // Register offsets and status field positions
    // ************************************************************
    localparam logic [7:0] REG_PC_LOW_BYTE = 8'h00;
    localparam logic [7:0] REG_BANK        = 8'h01;
    localparam logic [7:0] REG_STATUS      = 8'h02;
    localparam int         FLG_C      = 0;
    localparam int         FLG_AC     = 1;
    localparam int         FLG_Z      = 2;
    localparam int         FLG_OV     = 3;

    // ************************************************************
    // Sequencing decisions and ALU operations
    // ************************************************************
    typedef enum logic [2:0] {
        SEQ_NEXT = 3'b000,
        SEQ_JUMP = 3'b001,
        SEQ_CALL = 3'b010,
        SEQ_SUBROUTINE_RETURN = 3'b011,
        SEQ_INTERRUPT_RETURN  = 3'b100,
        SEQ_SKZ  = 3'b101,
        SEQ_SKNZ = 3'b110
    } cps_seq_op_t;

    typedef enum logic [3:0] {
        ALU_ADD  = 4'b0000,
        ALU_ADC  = 4'b0001,
        ALU_SUB  = 4'b0010,
        ALU_SBC  = 4'b0011,
        ALU_DAA  = 4'b0100,
        ALU_AND  = 4'b0101,
        ALU_OR   = 4'b0110,
        ALU_XOR  = 4'b0111,
        ALU_CPL  = 4'b1000,
        ALU_RR   = 4'b1001,
        ALU_RRC  = 4'b1010,
        ALU_RL   = 4'b1011,
        ALU_RLC  = 4'b1100,
        ALU_INC  = 4'b1101,
        ALU_DEC  = 4'b1110,
        ALU_PASS = 4'b1111
    } cps_alu_op_t;

    localparam logic [8:0] DAA_LO = 9'h006;
    localparam logic [8:0] DAA_HI = 9'h060;
    localparam logic [3:0] BCD_MAX = 4'h9;

endpackage

// ===== design/cps_core.sv
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module cps_core #(
    parameter int         PC_W        = cps_pkg::PC_W,
    parameter int         INSTR_W     = cps_pkg::INSTR_W,
    parameter int         STACK_DEPTH = cps_pkg::STACK_DEPTH,
    parameter logic [1:0] BANK_MASK   = cps_pkg::BANK_MASK
) (
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    output logic [PC_W-1:0]         o_pmem_addr,
    output logic [1:0]              o_pmem_bank,
    input  wire logic [INSTR_W-1:0] i_pmem_data,
    output logic [1:0]              o_phase,
    output logic [INSTR_W-1:0]      o_instr,
    output logic                    o_instr_valid,
    input  wire logic [2:0]         i_seq_op,
    input  wire logic [PC_W-1:0]    i_target,
    input  wire logic               i_int_req,
    input  wire logic [PC_W-1:0]    i_int_vector,
    output logic                    o_int_ack,
    output logic                    o_stack_full,
    input  wire logic [3:0]         i_alu_op,
    input  wire logic [7:0]         i_alu_a,
    input  wire logic [7:0]         i_alu_b,
    input  wire logic               i_alu_we,
    output logic [7:0]              o_alu_result,
    output logic [3:0]              o_flags,
    input  wire logic [7:0]         i_addr,
    input  wire logic [7:0]         i_wdata,
    input  wire logic               i_we,
    input  wire logic               i_re,
    output logic [7:0]              o_rdata
);

    localparam int             SP_W    = $clog2(STACK_DEPTH + 1);
    localparam logic [SP_W-1:0] SP_ZERO = '0;
    localparam logic [SP_W-1:0] SP_ONE  = SP_W'(1);
    localparam logic [SP_W-1:0] SP_LAST = SP_W'(STACK_DEPTH - 1);
    localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

    typedef struct packed {
        logic [1:0]                        ph;
        logic [PC_W-1:0]                   pc;
        logic [INSTR_W-1:0]                ir;
        logic                              ir_valid;
        logic [STACK_DEPTH-1:0][PC_W-1:0]  stk;
        logic [SP_W-1:0]                   ptr;
        logic [SP_W-1:0]                   cnt;
        logic                              int_pend;
        logic                              int_ack;
        logic                              low_pend;
        logic [7:0]                        low_tgt;
        logic [7:0]                        bank;
        logic [3:0]                        flags;
        logic [7:0]                        alu_res;
        logic [7:0]                        rdata;
    } cps_state_t;

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] rst_sync_q;
    logic       rstn_s;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rstn_s = rst_sync_q[1];

    // ************************************************************
    // ALU
    // ************************************************************
    cps_state_t          q;
    cps_state_t          d;
    cps_pkg::cps_alu_op_t aop;
    cps_pkg::cps_seq_op_t sop;
    logic [7:0]          bx;
    logic                ci;
    logic [8:0]          sum9;
    logic [4:0]          nib5;
    logic [8:0]          daa1;
    logic [8:0]          daa2;
    logic [7:0]          res;
    logic [3:0]          flg;
    logic                res_zero;

    assign aop = cps_pkg::cps_alu_op_t'(i_alu_op);
    assign sop = cps_pkg::cps_seq_op_t'(i_seq_op);

    always_comb begin
        bx   = (aop == cps_pkg::ALU_SUB || aop == cps_pkg::ALU_SBC)
               ? ~i_alu_b : i_alu_b;
        case (aop)
            cps_pkg::ALU_ADC: ci = q.flags[cps_pkg::FLG_C];
            cps_pkg::ALU_SUB: ci = 1'b1;
            cps_pkg::ALU_SBC: ci = q.flags[cps_pkg::FLG_C];
            default:          ci = 1'b0;
        endcase
        sum9 = {1'b0, i_alu_a} + {1'b0, bx} + {8'h00, ci};
        nib5 = {1'b0, i_alu_a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
        daa1 = {1'b0, i_alu_a} +
               ((i_alu_a[3:0] > cps_pkg::BCD_MAX || q.flags[cps_pkg::FLG_AC])
               ? cps_pkg::DAA_LO : 9'h000);
        daa2 = daa1 +
               ((daa1[7:4] > cps_pkg::BCD_MAX || daa1[8] ||
                 q.flags[cps_pkg::FLG_C]) ? cps_pkg::DAA_HI : 9'h000);
        flg  = q.flags;
        res  = i_alu_a;
        case (aop)
            cps_pkg::ALU_ADD, cps_pkg::ALU_ADC,
            cps_pkg::ALU_SUB, cps_pkg::ALU_SBC: begin
                // Carry set means no borrow on subtraction
                res                   = sum9[7:0];
                flg[cps_pkg::FLG_C]   = sum9[8];
                flg[cps_pkg::FLG_AC]  = nib5[4];
                flg[cps_pkg::FLG_OV]  = (i_alu_a[7] == bx[7]) &&
                                        (sum9[7] != i_alu_a[7]);
            end
            cps_pkg::ALU_DAA: begin
                res                 = daa2[7:0];
                flg[cps_pkg::FLG_C] = daa2[8] | q.flags[cps_pkg::FLG_C];
            end
            cps_pkg::ALU_AND:  res = i_alu_a & i_alu_b;
            cps_pkg::ALU_OR:   res = i_alu_a | i_alu_b;
            cps_pkg::ALU_XOR:  res = i_alu_a ^ i_alu_b;
            cps_pkg::ALU_CPL:  res = ~i_alu_a;
            cps_pkg::ALU_RR:   res = {i_alu_a[0], i_alu_a[7:1]};
            cps_pkg::ALU_RL:   res = {i_alu_a[6:0], i_alu_a[7]};
            cps_pkg::ALU_RRC: begin
                res                 = {q.flags[cps_pkg::FLG_C], i_alu_a[7:1]};
                flg[cps_pkg::FLG_C] = i_alu_a[0];
            end
            cps_pkg::ALU_RLC: begin
                res                 = {i_alu_a[6:0], q.flags[cps_pkg::FLG_C]};
                flg[cps_pkg::FLG_C] = i_alu_a[7];
            end
            cps_pkg::ALU_INC:  res = i_alu_a + 8'h01;
            cps_pkg::ALU_DEC:  res = i_alu_a - 8'h01;
            default:           res = i_alu_a;
        endcase
        res_zero = (res == 8'h00);
        // Rotates leave the zero flag alone
        if (!(aop inside {cps_pkg::ALU_RR, cps_pkg::ALU_RL,
                          cps_pkg::ALU_RRC, cps_pkg::ALU_RLC})) begin
            flg[cps_pkg::FLG_Z] = res_zero;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    logic            at_t4;
    logic            do_branch;
    logic            do_push;
    logic            do_pop;
    logic            do_skip;
    logic            do_int;
    logic [SP_W-1:0] ptr_inc;
    logic [SP_W-1:0] ptr_dec;
    logic [7:0]      rd_mux;

    always_comb begin
        at_t4     = (q.ph == cps_pkg::PH_T4);
        do_push   = at_t4 && q.ir_valid && sop == cps_pkg::SEQ_CALL;
        do_pop    = at_t4 && q.ir_valid &&
                    (sop == cps_pkg::SEQ_SUBROUTINE_RETURN ||
                     sop == cps_pkg::SEQ_INTERRUPT_RETURN);
        do_branch = do_push || do_pop ||
                    (at_t4 && q.ir_valid && sop == cps_pkg::SEQ_JUMP);
        do_skip   = at_t4 && q.ir_valid &&
                    ((sop == cps_pkg::SEQ_SKZ && res_zero) ||
                     (sop == cps_pkg::SEQ_SKNZ && !res_zero));
        do_int    = at_t4 && !do_branch && !do_skip && q.int_pend &&
                    (q.cnt != SP_FULL);
        ptr_inc   = (q.ptr == SP_LAST) ? SP_ZERO : q.ptr + SP_ONE;
        ptr_dec   = (q.ptr == SP_ZERO) ? SP_LAST : q.ptr - SP_ONE;
        case (i_addr)
            cps_pkg::REG_PC_LOW_BYTE: rd_mux = q.pc[7:0];
            cps_pkg::REG_BANK:   rd_mux = q.bank;
            cps_pkg::REG_STATUS: rd_mux = {3'h0, q.int_pend, q.flags};
            default:             rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        d         = q;
        d.ph      = q.ph + 2'h1;
        d.int_ack = 1'b0;
        d.rdata   = i_re ? rd_mux : 8'h00;
        if (at_t4) begin
            d.ir       = i_pmem_data;
            d.ir_valid = 1'b1;
            d.pc       = q.pc + PC_W'(1);
            if (q.ir_valid && i_alu_we) begin
                d.alu_res = res;
                d.flags   = flg;
            end
            if (do_branch) begin
                d.ir_valid = 1'b0;
                d.pc       = i_target;
                if (do_push) begin
                    d.stk[q.ptr] = q.pc;
                    d.ptr        = ptr_inc;
                    d.cnt        = (q.cnt == SP_FULL) ? SP_FULL
                                                      : q.cnt + SP_ONE;
                end else if (do_pop) begin
                    d.pc = q.stk[ptr_dec];
                    if (q.cnt != SP_ZERO) begin
                        // Emptied stack returns the pointer to slot zero
                        d.ptr = (q.cnt == SP_ONE) ? SP_ZERO : ptr_dec;
                        d.cnt = q.cnt - SP_ONE;
                    end
                end
            end else if (do_skip) begin
                d.ir_valid = 1'b0;
            end else if (do_int) begin
                d.ir_valid     = 1'b0;
                d.pc           = i_int_vector;
                d.stk[q.ptr]   = q.pc;
                d.ptr          = ptr_inc;
                d.cnt          = q.cnt + SP_ONE;
                d.int_pend     = 1'b0;
                d.int_ack      = 1'b1;
            end else if (q.low_pend) begin
                d.ir_valid = 1'b0;
                d.pc       = {q.pc[PC_W-1:8], q.low_tgt};
                d.low_pend = 1'b0;
            end
        end
        if (i_int_req) begin
            d.int_pend = 1'b1;
        end
        if (i_we && i_addr == cps_pkg::REG_PC_LOW_BYTE) begin
            d.low_pend = 1'b1;
            d.low_tgt  = i_wdata;
        end
        if (i_we && i_addr == cps_pkg::REG_BANK) begin
            d.bank = i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge rstn_s) begin
        if (!rstn_s) begin
            q      <= '0;
            q.pc   <= cps_pkg::RESET_PC;
            q.ph   <= cps_pkg::PH_T1;
            q.bank <= cps_pkg::BANK_RESET;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // bank bits extend address
    assign o_pmem_addr   = q.pc;
    assign o_pmem_bank   = q.bank[cps_pkg::BANK_LSB+1:cps_pkg::BANK_LSB]
                           & BANK_MASK;
    assign o_phase       = q.ph;
    assign o_instr       = q.ir;
    assign o_instr_valid = q.ir_valid;
    assign o_int_ack     = q.int_ack;
    assign o_stack_full  = (q.cnt == SP_FULL);
    assign o_alu_result  = q.alu_res;
    assign o_flags       = q.flags;
    assign o_rdata       = q.rdata;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_dummy_then_real;
        !q.ir_valid ##4 q.ir_valid;
    endsequence

    property p_phase_step;
        @(posedge i_clk) disable iff (!rstn_s)
        q.ph == cps_pkg::PH_T4 |=> q.ph == cps_pkg::PH_T1 ##3
            q.ph == cps_pkg::PH_T4;
    endproperty
    a_phase_step: assert property (p_phase_step)
        else $error("phase sequence broken");

    property p_seq_inc;
        @(posedge i_clk) disable iff (!rstn_s)
        at_t4 && !do_branch && !do_skip && !do_int && !q.low_pend
        |=> q.pc == $past(q.pc) + PC_W'(1) && q.ir_valid;
    endproperty
    a_seq_inc: assert property (p_seq_inc)
        else $error("counter did not step by one");

    property p_jump_dummy;
        @(posedge i_clk) disable iff (!rstn_s)
        at_t4 && q.ir_valid && sop == cps_pkg::SEQ_JUMP
        |=> q.pc == $past(i_target) ##0 s_dummy_then_real;
    endproperty
    a_jump_dummy: assert property (p_jump_dummy)
        else $error("jump did not insert one dummy cycle");

    property p_skip_dummy;
        @(posedge i_clk) disable iff (!rstn_s)
        do_skip |=> q.pc == $past(q.pc) + PC_W'(1) ##0 s_dummy_then_real;
    endproperty
    a_skip_dummy: assert property (p_skip_dummy)
        else $error("skip did not discard prefetch");

    property p_low_jump;
        @(posedge i_clk) disable iff (!rstn_s)
        at_t4 && q.low_pend && !do_branch && !do_skip && !do_int
        |=> q.pc == {$past(q.pc[PC_W-1:8]), $past(q.low_tgt)} && !q.ir_valid;
    endproperty
    a_low_jump: assert property (p_low_jump)
        else $error("low byte write did not redirect");

    property p_low_latch;
        @(posedge i_clk) disable iff (!rstn_s)
        i_we && i_addr == cps_pkg::REG_PC_LOW_BYTE
        |=> q.low_pend && q.low_tgt == $past(i_wdata);
    endproperty
    a_low_latch: assert property (p_low_latch)
        else $error("low byte write not held for the next fetch");

    property p_push_count;
        @(posedge i_clk) disable iff (!rstn_s)
        do_push |=> q.cnt == (($past(q.cnt) == SP_FULL) ? SP_FULL
                              : $past(q.cnt) + SP_ONE);
    endproperty
    a_push_count: assert property (p_push_count)
        else $error("stack depth wrong after call");

    property p_int_defer;
        @(posedge i_clk) disable iff (!rstn_s)
        at_t4 && q.int_pend && q.cnt == SP_FULL |=> !q.int_ack;
    endproperty
    a_int_defer: assert property (p_int_defer)
        else $error("interrupt acknowledged on full stack");

    property p_ret_restore;
        @(posedge i_clk) disable iff (!rstn_s)
        do_pop && q.cnt != SP_ZERO |=> q.pc == $past(q.stk[ptr_dec])
            && q.cnt == $past(q.cnt) - SP_ONE;
    endproperty
    a_ret_restore: assert property (p_ret_restore)
        else $error("return did not restore counter");

    property p_empty_ret;
        @(posedge i_clk) disable iff (!rstn_s)
        do_pop && q.cnt == SP_ZERO |=> q.cnt == SP_ZERO && q.ptr == SP_ZERO;
    endproperty
    a_empty_ret: assert property (p_empty_ret)
        else $error("empty return moved the pointer");

    property p_reset_start;
        @(posedge i_clk) $rose(rstn_s) |-> q.pc == cps_pkg::RESET_PC
            && q.cnt == SP_ZERO ##4 q.pc == cps_pkg::RESET_PC + PC_W'(1);
    endproperty
    a_reset_start: assert property (p_reset_start)
        else $error("execution did not start at zero");

endmodule

`default_nettype wire

// ===== tb/cps_partner.sv
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Program memory and interrupt source
// ************************************************************
module cps_partner #(
    parameter logic [12:0] VEC = 13'h0004
) (
    input  wire logic        i_clk,
    input  wire logic [12:0] i_addr,
    input  wire logic [1:0]  i_bank,
    input  wire logic        i_fire,
    output logic [15:0]      o_data,
    output logic             o_int_req,
    output logic [12:0]      o_vector
);
    // Bank folded into the word, so a wrong bank reads as bad data
    assign o_data   = {1'b0, i_bank, i_addr} ^ 16'h5A3C;
    assign o_vector = VEC;

    // Request lasts one cycle only; the core must hold it itself
    always_ff @(posedge i_clk) begin
        o_int_req <= i_fire;
    end
endmodule

`default_nettype wire

// ===== tb/cpu_program_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none

module cpu_program_sequencer_tb;
    localparam logic [12:0] VEC = 13'h0004;

    logic        i_clk = 1'b0, i_rstn = 1'b0, fire = 1'b0, run = 1'b0;
    logic        i_we = 1'b0, i_re = 1'b0, i_alu_we = 1'b0;
    logic        i_int_req, o_int_ack, o_stack_full, o_instr_valid;
    logic        m_val = 1'b0, m_c = 1'b0, m_z = 1'b0, m_chk = 1'b1;
    logic        m_pw = 1'b0;
    logic [1:0]  o_pmem_bank, o_phase, ph_q, m_bank = 2'h0, m_av = 2'h0;
    logic [2:0]  i_seq_op = 3'h0;
    logic [3:0]  i_alu_op = 4'h0, o_flags, aop;
    logic [7:0]  i_alu_a = 8'h00, i_alu_b = 8'h00, i_addr = 8'h00;
    logic [7:0]  i_wdata = 8'h00, o_alu_result, o_rdata, m_pwd;
    logic [12:0] i_target = 13'h0000, o_pmem_addr, i_int_vector;
    logic [12:0] m_pc = 13'h0000, ack_pc;
    logic [15:0] i_pmem_data, o_instr;
    logic [31:0] s = 32'h741D;
    logic [12:0] stk[$];
    int          n_errors = 0, total_checks = 0, n_ack = 0, k;

    cps_core i_dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .o_pmem_addr(o_pmem_addr),
        .o_pmem_bank(o_pmem_bank), .i_pmem_data(i_pmem_data),
        .o_phase(o_phase), .o_instr(o_instr), .o_instr_valid(o_instr_valid),
        .i_seq_op(i_seq_op), .i_target(i_target), .i_int_req(i_int_req),
        .i_int_vector(i_int_vector), .o_int_ack(o_int_ack),
        .o_stack_full(o_stack_full), .i_alu_op(i_alu_op),
        .i_alu_a(i_alu_a), .i_alu_b(i_alu_b), .i_alu_we(i_alu_we),
        .o_alu_result(o_alu_result), .o_flags(o_flags), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata)
    );

    cps_partner #(.VEC(VEC)) i_mem (
        .i_clk(i_clk), .i_addr(o_pmem_addr), .i_bank(o_pmem_bank),
        .i_fire(fire), .o_data(i_pmem_data), .o_int_req(i_int_req),
        .o_vector(i_int_vector)
    );

    always #4 i_clk = ~i_clk;

    task automatic stop_test();
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ************************************************************
    // Reference model
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Codes follow cps_alu_op_t; decimal adjust only for BCD-clean input
    function automatic logic [8:0] alu_model(input logic [3:0] op,
        input logic [7:0] a, input logic [7:0] b, input logic c);
        case (op)
            4'h0: return {1'b0, a} + {1'b0, b};
            4'h1: return {1'b0, a} + {1'b0, b} + {8'h00, c};
            4'h2: return {1'b0, a} + {1'b0, ~b} + 9'h001;
            4'h3: return {1'b0, a} + {1'b0, ~b} + {8'h00, c};
            4'h5: return {c, a & b};
            4'h6: return {c, a | b};
            4'h7: return {c, a ^ b};
            4'h8: return {c, ~a};
            4'h9: return {c, a[0], a[7:1]};
            4'hA: return {a[0], c, a[7:1]};
            4'hB: return {c, a[6:0], a[7]};
            4'hC: return {a[7], a[6:0], c};
            4'hD: return {c, a + 8'h01};
            4'hE: return {c, a - 8'h01};
            default: return {c, a};
        endcase
    endfunction

    // One instruction: inputs set in T4, outputs checked after its edge
    task automatic exec(input logic [2:0] op, input logic [12:0] tgt,
        input logic [3:0] ao, input logic [7:0] a, input logic [7:0] b,
        input logic we);
        logic [8:0]  r;
        logic [15:0] ei;
        logic        was;
        logic        sk;
        logic [7:0]  bb;
        do @(posedge i_clk); while (o_phase !== 2'h2);
        i_seq_op <= op;
        i_target <= tgt;
        i_alu_op <= ao;
        i_alu_a  <= a;
        i_alu_b  <= b;
        i_alu_we <= we;
        was = m_val;
        ei  = {1'b0, m_bank, m_pc} ^ 16'h5A3C;
        r   = alu_model(ao, a, b, m_c);
        @(posedge i_clk);
        #1;
        if (was && we) begin
            if (ao < 4'h9 || ao > 4'hC)
                m_z = (r[7:0] == 8'h00);
            if (ao < 4'h4 || ao == 4'hA || ao == 4'hC)
                m_c = r[8];
            chk(o_alu_result, r[7:0]);
            chk(o_flags[cps_pkg::FLG_Z], m_z);
            chk(o_flags[cps_pkg::FLG_C], m_c);
            // Carry into bit 4 gives half carry; carries into bits 7 and 8 give overflow
            bb = (ao == 4'h2 || ao == 4'h3) ? ~b : b;
            if (ao < 4'h4)
                m_av = {r[7] ^ a[7] ^ bb[7] ^ r[8], r[4] ^ a[4] ^ bb[4]};
            chk(o_flags[cps_pkg::FLG_OV], m_av[1]);
            chk(o_flags[cps_pkg::FLG_AC], m_av[0]);
        end
        sk = (op == 3'h5 && m_z) || (op == 3'h6 && !m_z);
        if (!was) begin
            m_val = 1'b1;
            m_pc  = m_pc + 13'h0001;
        end else if (op == 3'h1 || op == 3'h2) begin
            if (op == 3'h2)
                stk.push_back(m_pc);
            // Overflow drops the oldest entry
            if (stk.size() > 12)
                void'(stk.pop_front());
            m_pc  = tgt;
            m_chk = 1'b1;
            m_val = 1'b0;
        end else if (op == 3'h3 || op == 3'h4) begin
            if (stk.size() == 0)
                m_chk = 1'b0;
            else
                m_pc = stk.pop_back();
            m_val = 1'b0;
        end else if (sk || m_pw) begin
            m_pc  = sk ? m_pc + 13'h0001 : {m_pc[12:8], m_pwd};
            m_pw  = m_pw & sk;
            m_val = 1'b0;
        end else
            m_pc = m_pc + 13'h0001;
        if (m_chk)
            chk(o_pmem_addr, m_pc);
        if (m_chk && m_val)
            chk(o_instr, ei);
        chk(o_instr_valid, m_val);
        chk(o_pmem_bank, m_bank);
        chk(o_stack_full, stk.size() == 12);
    endtask

    task automatic br(input logic [2:0] op, input logic [12:0] tgt);
        exec(op, tgt, 4'h0, 8'h00, 8'h00, 1'b0);
    endtask

    task automatic step();
        br(3'h0, 13'h0000);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_we    <= 1'b1;
        @(posedge i_clk);
        i_we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_re   <= 1'b1;
        @(posedge i_clk);
        i_re <= 1'b0;
        #1;
        chk(o_rdata, e);
    endtask

    always @(posedge i_clk) begin
        if (o_int_ack === 1'b1) begin
            n_ack++;
            ack_pc = o_pmem_addr;
        end
        if (run)
            chk(o_phase, 2'(ph_q + 2'h1));
        ph_q <= o_phase;
    end

    // Whole run is about 550 cycles; the margin is generous
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        stop_test();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (12) @(posedge i_clk);
        chk(o_pmem_addr, 13'h0000);
        chk(o_phase, 2'h0);
        i_rstn <= 1'b1;
        step();
        run = 1'b1;
        repeat (3) step();
        for (k = 0; k < 28; k++) begin
            s   = lfsr(s);
            aop = 4'(k % 14);
            if (aop > 4'h3)
                aop = aop + 4'h1;
            exec(3'h0, 13'h0000, aop, s[7:0], s[15:8], 1'b1);
        end
        exec(3'h0, 13'h0000, 4'h0, 8'h00, 8'h00, 1'b1);
        exec(3'h0, 13'h0000, 4'h4, 8'h45, 8'h00, 1'b1);
        exec(3'h0, 13'h0000, 4'h5, 8'h0F, 8'hF0, 1'b1);
        exec(3'h5, 13'h0000, 4'h5, 8'h0F, 8'hF0, 1'b1);
        step();
        exec(3'h6, 13'h0000, 4'h5, 8'h0F, 8'hF0, 1'b1);
        exec(3'h6, 13'h0000, 4'h6, 8'h0F, 8'hF0, 1'b1);
        step();
        br(3'h1, 13'h0A10);
        step();
        rd(8'h00, m_pc[7:0]);
        step();
        wr(8'h00, 8'hC3);
        m_pw  = 1'b1;
        m_pwd = 8'hC3;
        step();
        step();
        wr(8'h01, 8'h60);
        m_bank = 2'h3;
        step();
        rd(8'h01, 8'h60);
        step();
        rd(8'h03, 8'h00);
        for (k = 0; k < 13; k++) begin
            s = lfsr(s);
            br(3'h2, s[12:0]);
            step();
        end
        for (k = 0; k < 13; k++) begin
            br(3'h3 + 3'(k % 2), 13'h0000);
            step();
        end
        br(3'h1, 13'h0100);
        step();
        for (k = 0; k < 12; k++) begin
            s = lfsr(s);
            br(3'h2, s[12:0]);
            step();
        end
        @(posedge i_clk);
        fire <= 1'b1;
        @(posedge i_clk);
        fire <= 1'b0;
        repeat (2) step();
        chk(16'(n_ack), 16'h0000);
        br(3'h3, 13'h0000);
        @(posedge i_clk);
        i_seq_op <= 3'h0;
        repeat (12) @(posedge i_clk);
        #1;
        chk(16'(n_ack), 16'h0001);
        chk(ack_pc, VEC);
        stop_test();
    end
endmodule

`default_nettype wire
